// File: pkg/pm_params.svh
`ifndef PM_PARAMS_SVH
`define PM_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define PM_IDX_P2_DATA   32'hfffff011
`define PM_IDX_P2_FUNC   32'hfffff016
`define PM_IDX_P2_DIR    32'hfffff017
`define PM_IDX_P3_FUNC   32'hfffff018
`define PM_IDX_P3_DIR    32'hfffff019
`define PM_IDX_P3_DATA   32'hfffff01b
`define PM_IDX_P4_DATA   32'hfffff01d
`define PM_IDX_P4_FUNC   32'hfffff022
`define PM_IDX_P4_DIR    32'hfffff023
`define PM_IDX_P5_DATA   32'hfffff02b
`define PM_IDX_P5_FUNC   32'hfffff02e
`define PM_IDX_P5_DIR    32'hfffff02f
// strap and start-up status, byte address
`define PM_ADDR_STATUS   12'hffc

// implemented bit masks
`define PM_MASK_FULL     8'hff
`define PM_MASK_P3_DIR   8'hfc
`define PM_MASK_P4       8'h1f

// reset values before the straps are taken
`define PM_RST_P2_DATA   8'h00
`define PM_RST_P2_CTRL   8'h00
`define PM_RST_P3_FUNC   8'h00
`define PM_RST_P3_DATA   8'h03
`define PM_RST_P3_DIR    8'h00
`define PM_RST_P4_DATA   8'h10
`define PM_RST_P4_CTRL   8'h00
`define PM_RST_P5_DATA   8'hff
`define PM_RST_P5_CTRL   8'h00

// strap-dependent fields
`define PM_P3_PU_FIELD   8'h7c
`define PM_P3_PIN7       8'h80
`define PM_P4_PU_FIELD   8'h0f

// status bits
`define PM_ST_BUSMODE    0
`define PM_ST_PULLUP     1
`define PM_ST_READY      2

`endif

// File: pkg/pm_pkg.sv
package pm_pkg;

    // function/direction pair of one pin
    typedef enum logic [1:0] {
        PM_FN_IN     = 2'b00,
        PM_FN_OUT    = 2'b01,
        PM_FN_ALT_LO = 2'b10,
        PM_FN_ALT_HI = 2'b11
    } pm_pinfn_t;

    // start-up sequence: straps are caught after reset release
    typedef enum logic [0:0] {
        PM_ST_STRAP = 1'b0,
        PM_ST_RUN   = 1'b1
    } pm_init_t;

endpackage

// File: rtl/pm_port_mux.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pm_params.svh"

// Summary of operation
// - port two pair: 00 in, 01 out, 10 address 7..0, 11 address 23..16
// - reset clears port two latch; all its pins come up as inputs
// - port three pins 0 and 1 always drive, as port or strobe
// - port three latch: bits 0,1 set; bits 2..6 follow pull-up select
// - port three latch bit 7 set in separate bus, clear in multiplexed
// - port three direction bits 2..6 reset to input; bits 0,1 absent
// - port three direction bit 7 resets to input or output by bus mode
// - port three function bits clear at reset; pull-ups follow strap
// - port three pin 0 with function bit set carries read strobe
// - port three pin 1 with function bit set carries write strobe
// - bus grant acknowledge enables pull-ups on pins 2 and 6 if selected
// - port four pins 0..3: port when function 0, chip select when 1
// - port four pin 4: port when function 0, system clock out when 1
// - port four latch: bit 4 set; bits 0..3 follow pull-up select
// - port four direction and function clear; pin 4 pull-up off
// - port five latch all ones, direction and function cleared
// - port five address function exists only in separate bus mode
// - port five pair: 00 in, 01 out, 10 in, 11 address 7..0
module pm_port_mux
    import pm_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    // clock, reset, enable
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // straps
    input  wire logic              bus_mode_strap,
    input  wire logic              reset_pullup_select,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // external bus controller
    input  wire logic [23:0]       ext_addr,
    input  wire logic              ext_rd_n,
    input  wire logic              ext_wr_n,
    input  wire logic [3:0]        chip_select_n,
    input  wire logic              sysclk,
    input  wire logic              bus_grant_ack,
    // port two pins
    input  wire logic [7:0]        p2_in,
    output logic      [7:0]        p2_out,
    output logic      [7:0]        p2_oe,
    // port three pins
    input  wire logic [7:0]        p3_in,
    output logic      [7:0]        p3_out,
    output logic      [7:0]        p3_oe,
    output logic      [7:0]        p3_pullup,
    // port four pins
    input  wire logic [4:0]        p4_in,
    output logic      [4:0]        p4_out,
    output logic      [4:0]        p4_oe,
    output logic      [4:0]        p4_pullup,
    // port five pins
    input  wire logic [7:0]        p5_in,
    output logic      [7:0]        p5_out,
    output logic      [7:0]        p5_oe,
    // mode seen by the core
    output logic                   separate_bus
);

    localparam logic [ADDR_W-1:0] A_P2_DATA =
        ADDR_W'(`PM_IDX_P2_DATA * 4);
    localparam logic [ADDR_W-1:0] A_P2_FUNC =
        ADDR_W'(`PM_IDX_P2_FUNC * 4);
    localparam logic [ADDR_W-1:0] A_P2_DIR  =
        ADDR_W'(`PM_IDX_P2_DIR * 4);
    localparam logic [ADDR_W-1:0] A_P3_FUNC =
        ADDR_W'(`PM_IDX_P3_FUNC * 4);
    localparam logic [ADDR_W-1:0] A_P3_DIR  =
        ADDR_W'(`PM_IDX_P3_DIR * 4);
    localparam logic [ADDR_W-1:0] A_P3_DATA =
        ADDR_W'(`PM_IDX_P3_DATA * 4);
    localparam logic [ADDR_W-1:0] A_P4_DATA =
        ADDR_W'(`PM_IDX_P4_DATA * 4);
    localparam logic [ADDR_W-1:0] A_P4_FUNC =
        ADDR_W'(`PM_IDX_P4_FUNC * 4);
    localparam logic [ADDR_W-1:0] A_P4_DIR  =
        ADDR_W'(`PM_IDX_P4_DIR * 4);
    localparam logic [ADDR_W-1:0] A_P5_DATA =
        ADDR_W'(`PM_IDX_P5_DATA * 4);
    localparam logic [ADDR_W-1:0] A_P5_FUNC =
        ADDR_W'(`PM_IDX_P5_FUNC * 4);
    localparam logic [ADDR_W-1:0] A_P5_DIR  =
        ADDR_W'(`PM_IDX_P5_DIR * 4);
    localparam logic [ADDR_W-1:0] A_STATUS  =
        ADDR_W'(`PM_ADDR_STATUS);

    // register state
    logic [7:0] p2_data;
    logic [7:0] p2_func;
    logic [7:0] p2_dir;
    logic [7:0] p3_data;
    logic [7:0] p3_func;
    logic [7:0] p3_dir;
    logic [7:0] p4_data;
    logic [7:0] p4_func;
    logic [7:0] p4_dir;
    logic [7:0] p5_data;
    logic [7:0] p5_func;
    logic [7:0] p5_dir;

    // straps and start-up
    pm_init_t   init_state;
    logic       bus_muxed;
    logic       pullup_sel;

    // bus decode
    logic       setup_ph;
    logic       wr_en;
    logic [7:0] wbyte;
    logic       addr_hit;
    logic [7:0] next_rdata;
    logic [7:0] p2_view;
    logic [7:0] p3_view;
    logic [7:0] p4_view;
    logic [7:0] p5_view;

    assign setup_ph = psel && !penable;
    assign wr_en    = clk_en && psel && penable && pwrite
                      && init_state == PM_ST_RUN;
    assign wbyte    = pwdata[7:0];
    // zero wait states: data is fetched in the setup cycle
    assign pready   = 1'b1;

    assign separate_bus = !bus_muxed;

    // strap capture; async reset only loads constants, straps land after
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            init_state <= PM_ST_STRAP;
            bus_muxed  <= 1'b0;
            pullup_sel <= 1'b0;
        end
        else if (clk_en)
        begin
            case (init_state)
                PM_ST_STRAP:
                begin
                    bus_muxed  <= bus_mode_strap;
                    pullup_sel <= reset_pullup_select;
                    init_state <= PM_ST_RUN;
                end
                PM_ST_RUN:
                begin
                    init_state <= PM_ST_RUN;
                end
                default:
                begin
                    init_state <= PM_ST_STRAP;
                end
            endcase
        end
    end

    // port two registers
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p2_data <= `PM_RST_P2_DATA;
            p2_func <= `PM_RST_P2_CTRL;
            p2_dir  <= `PM_RST_P2_CTRL;
        end
        else if (wr_en)
        begin
            if (paddr == A_P2_DATA)
                p2_data <= wbyte;
            if (paddr == A_P2_FUNC)
                p2_func <= wbyte;
            if (paddr == A_P2_DIR)
                p2_dir <= wbyte;
        end
    end

    // port three registers; strap fields fill in the start-up cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p3_data <= `PM_RST_P3_DATA;
            p3_func <= `PM_RST_P3_FUNC;
            p3_dir  <= `PM_RST_P3_DIR;
        end
        else if (clk_en && init_state == PM_ST_STRAP)
        begin
            p3_data <= `PM_RST_P3_DATA
                       | (reset_pullup_select ? `PM_P3_PU_FIELD
                                              : 8'h00)
                       | (bus_mode_strap ? 8'h00
                                         : `PM_P3_PIN7);
            p3_dir  <= bus_mode_strap ? `PM_P3_PIN7 : 8'h00;
        end
        else if (wr_en)
        begin
            if (paddr == A_P3_DATA)
                p3_data <= wbyte;
            if (paddr == A_P3_FUNC)
                p3_func <= wbyte;
            if (paddr == A_P3_DIR)
                p3_dir <= wbyte & `PM_MASK_P3_DIR;
        end
    end

    // port four registers; bits 7..5 do not exist
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p4_data <= `PM_RST_P4_DATA;
            p4_func <= `PM_RST_P4_CTRL;
            p4_dir  <= `PM_RST_P4_CTRL;
        end
        else if (clk_en && init_state == PM_ST_STRAP)
        begin
            p4_data <= `PM_RST_P4_DATA
                       | (reset_pullup_select ? `PM_P4_PU_FIELD
                                              : 8'h00);
        end
        else if (wr_en)
        begin
            if (paddr == A_P4_DATA)
                p4_data <= wbyte & `PM_MASK_P4;
            if (paddr == A_P4_FUNC)
                p4_func <= wbyte & `PM_MASK_P4;
            if (paddr == A_P4_DIR)
                p4_dir <= wbyte & `PM_MASK_P4;
        end
    end

    // port five registers
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p5_data <= `PM_RST_P5_DATA;
            p5_func <= `PM_RST_P5_CTRL;
            p5_dir  <= `PM_RST_P5_CTRL;
        end
        else if (wr_en)
        begin
            if (paddr == A_P5_DATA)
                p5_data <= wbyte;
            if (paddr == A_P5_FUNC)
                p5_func <= wbyte;
            if (paddr == A_P5_DIR)
                p5_dir <= wbyte;
        end
    end

    // reads show the pin for inputs and the latch for driven pins
    assign p2_view = (p2_in & ~p2_oe) | (p2_data & p2_oe);
    assign p3_view = (p3_in & ~p3_oe) | (p3_data & p3_oe);
    assign p4_view = {3'h0, (p4_in & ~p4_oe) | (p4_data[4:0] & p4_oe)};
    assign p5_view = (p5_in & ~p5_oe) | (p5_data & p5_oe);

    // function and direction registers are write-only and read zero
    always_comb
    begin
        next_rdata = 8'h00;
        addr_hit   = 1'b1;
        case (paddr)
            A_P2_DATA: next_rdata = p2_view;
            A_P3_DATA: next_rdata = p3_view;
            A_P4_DATA: next_rdata = p4_view;
            A_P5_DATA: next_rdata = p5_view;
            A_P2_FUNC, A_P2_DIR, A_P3_FUNC, A_P3_DIR,
            A_P4_FUNC, A_P4_DIR, A_P5_FUNC, A_P5_DIR:
                next_rdata = 8'h00;
            A_STATUS:
            begin
                next_rdata[`PM_ST_BUSMODE] = bus_muxed;
                next_rdata[`PM_ST_PULLUP]  = pullup_sel;
                next_rdata[`PM_ST_READY]   = init_state == PM_ST_RUN;
            end
            default:   addr_hit = 1'b0;
        endcase
    end

    // answer is captured in the setup cycle, shown in the access cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clk_en && setup_ph)
        begin
            prdata  <= {24'h00_0000, pwrite ? 8'h00 : next_rdata};
            pslverr <= !addr_hit;
        end
    end

    // per-pin muxes for the two eight-pin address ports
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_addr_ports
            pm_pinfn_t fn2;
            pm_pinfn_t fn5;
            assign fn2 = pm_pinfn_t'({p2_func[i], p2_dir[i]});
            assign fn5 = pm_pinfn_t'({p5_func[i], p5_dir[i]});

            always_comb
            begin
                case (fn2)
                    PM_FN_IN:
                    begin
                        p2_out[i] = p2_data[i];
                        p2_oe[i]  = 1'b0;
                    end
                    PM_FN_OUT:
                    begin
                        p2_out[i] = p2_data[i];
                        p2_oe[i]  = 1'b1;
                    end
                    PM_FN_ALT_LO:
                    begin
                        p2_out[i] = ext_addr[i];
                        p2_oe[i]  = 1'b1;
                    end
                    PM_FN_ALT_HI:
                    begin
                        p2_out[i] = ext_addr[16+i];
                        p2_oe[i]  = 1'b1;
                    end
                    default:
                    begin
                        p2_out[i] = p2_data[i];
                        p2_oe[i]  = 1'b0;
                    end
                endcase
            end

            // multiplexed mode falls back to the latch on code 11
            always_comb
            begin
                case (fn5)
                    PM_FN_OUT:
                    begin
                        p5_out[i] = p5_data[i];
                        p5_oe[i]  = 1'b1;
                    end
                    PM_FN_ALT_HI:
                    begin
                        p5_out[i] = bus_muxed ? p5_data[i]
                                              : ext_addr[i];
                        p5_oe[i]  = 1'b1;
                    end
                    default:
                    begin
                        p5_out[i] = p5_data[i];
                        p5_oe[i]  = 1'b0;
                    end
                endcase
            end
        end
    endgenerate

    // port three: pins 0 and 1 never float
    always_comb
    begin
        p3_out = p3_data;
        p3_oe  = p3_dir & `PM_MASK_P3_DIR;
        p3_oe[1:0] = 2'b11;
        if (p3_func[0])
            p3_out[0] = ext_rd_n;
        if (p3_func[1])
            p3_out[1] = ext_wr_n;
    end

    // pull-ups on inputs follow the latch, so the strap reaches them
    always_comb
    begin
        p3_pullup = ~p3_oe & p3_data & `PM_P3_PU_FIELD;
        if (bus_grant_ack && p3_func[2])
            p3_pullup[2] = 1'b1;
        if (bus_grant_ack && p3_func[6])
            p3_pullup[6] = 1'b1;
    end

    // port four: chip selects and clock out override the direction bit
    always_comb
    begin
        p4_out = p4_data[4:0];
        p4_oe  = p4_dir[4:0] | p4_func[4:0];
        for (int k = 0; k < 4; k++)
        begin
            if (p4_func[k])
                p4_out[k] = chip_select_n[k];
        end
        if (p4_func[4])
            p4_out[4] = sysclk;
    end

    // pin 4 never gets a pull-up
    always_comb
    begin
        p4_pullup    = ~p4_oe & p4_data[4:0];
        p4_pullup[4] = 1'b0;
    end

endmodule

`default_nettype wire

// File: verif/pm_port_mux_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pm_port_mux_monitor
#(
    parameter int ADDR_W = 12
)
(
    // clock, reset, straps
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic              clk_en,
    input wire logic              bus_mode_strap,
    input wire logic              reset_pullup_select,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic              pready,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    // core side
    input wire logic              ext_rd_n,
    input wire logic              ext_wr_n,
    input wire logic [3:0]        chip_select_n,
    input wire logic              sysclk,
    input wire logic              bus_grant_ack,
    // pins
    input wire logic [7:0]        p2_oe,
    input wire logic [7:0]        p3_out,
    input wire logic [7:0]        p3_oe,
    input wire logic [7:0]        p3_pullup,
    input wire logic [4:0]        p4_out,
    input wire logic [4:0]        p4_oe,
    input wire logic [4:0]        p4_pullup,
    input wire logic [7:0]        p5_out,
    input wire logic [7:0]        p5_oe
);
    logic [7:0] p3_fn;
    logic [4:0] p4_fn;
    logic       wr_ok;

    // function registers are write-only, so they are shadowed off the bus
    assign wr_ok = psel && penable && pwrite && pready && clk_en;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            p3_fn <= 8'h00;
        else if (wr_ok && paddr == ADDR_W'(12'h060))
            p3_fn <= pwdata[7:0];
    end
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            p4_fn <= 5'h00;
        else if (wr_ok && paddr == ADDR_W'(12'h088))
            p4_fn <= pwdata[4:0];
    end

    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // first enabled edge after release: the straps are taken here
    sequence released_s;
        $rose(rst_b) && clk_en;
    endsequence

    strap_dir_a: assert property (
        released_s |=> {p2_oe, p3_oe, p4_oe, p5_oe} ==
            {8'h00, $past(bus_mode_strap), 7'h03, 5'h00, 8'h00})
        else $error("pin directions wrong after start-up");
    strap_latch_a: assert property (
        released_s |=> {p3_out, p4_out, p5_out} ==
            {~$past(bus_mode_strap), {5{$past(reset_pullup_select)}},
             2'b11, 1'b1, {4{$past(reset_pullup_select)}}, 8'hff})
        else $error("output latches wrong after start-up");
    strap_pull_a: assert property (
        released_s |=> {p3_pullup, p4_pullup} ==
            {1'b0, {5{$past(reset_pullup_select)}}, 3'b000,
             {4{$past(reset_pullup_select)}}})
        else $error("pull-ups wrong after start-up");
    out_only_a: assert property (p3_oe[1:0] == 2'b11)
        else $error("port three pin 0 or 1 not driving");
    rd_strobe_a: assert property (
        p3_fn[0] |-> p3_out[0] == ext_rd_n)
        else $error("read strobe not routed");
    wr_strobe_a: assert property (
        p3_fn[1] |-> p3_out[1] == ext_wr_n)
        else $error("write strobe not routed");
    cs_route_a: assert property (
        p4_fn[3:0] != 4'h0 |->
            ((p4_out[3:0] ^ chip_select_n) & p4_fn[3:0]) == 4'h0)
        else $error("chip select not routed");
    sysclk_out_a: assert property (
        p4_fn[4] |-> p4_oe[4] && p4_out[4] == sysclk)
        else $error("system clock not routed");
    grant_pull_a: assert property (
        bus_grant_ack |-> (~p3_pullup & p3_fn & 8'h44) == 8'h00)
        else $error("pull-up missing during bus grant");
endmodule
`default_nettype wire

// File: verif/pm_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pm_pin_model
#(
    parameter int W = 8
)
(
    // clock
    input wire logic         mclk,
    // chip side drivers
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pullup,
    // far side drivers
    input wire logic [W-1:0] ext_drv,
    input wire logic         ext_en,
    // resolved level
    output logic     [W-1:0] pin_in
);
    logic tgl = 1'b0;

    // an undriven pin without pull-up must not look like a steady level
    always @(posedge mclk)
        tgl <= ~tgl;
    always_comb
    begin
        for (int i = 0; i < W; i++)
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en ? ext_drv[i] :
                        pin_pullup[i] ? 1'b1 : tgl;
    end
endmodule
`default_nettype wire

// File: verif/tb_ports_two_to_five_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ports_two_to_five_pin_mux;
    logic        mclk, rst_b, clk_en, bus_mode_strap, reset_pullup_select;
    logic        psel, penable, pwrite, pready, pslverr, rerr, ext_en;
    logic        ext_rd_n, ext_wr_n, sysclk, bus_grant_ack, separate_bus;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [23:0] ext_addr;
    logic [3:0]  chip_select_n;
    logic [7:0]  p2_in, p2_out, p2_oe, p3_in, p3_out, p3_oe, p3_pullup;
    logic [7:0]  p5_in, p5_out, p5_oe, exp2, ext_pat, no_pull;
    logic [4:0]  p4_in, p4_out, p4_oe, p4_pullup;
    logic        bm, pu;
    int          num_errors = 0;
    int          cmp_count = 0;

    always #5 mclk = ~mclk;

    pm_port_mux #(.ADDR_W(12)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
        .bus_mode_strap(bus_mode_strap),
        .reset_pullup_select(reset_pullup_select),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
        .ext_wr_n(ext_wr_n), .chip_select_n(chip_select_n),
        .sysclk(sysclk), .bus_grant_ack(bus_grant_ack),
        .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe),
        .p3_in(p3_in), .p3_out(p3_out), .p3_oe(p3_oe),
        .p3_pullup(p3_pullup), .p4_in(p4_in), .p4_out(p4_out),
        .p4_oe(p4_oe), .p4_pullup(p4_pullup), .p5_in(p5_in),
        .p5_out(p5_out), .p5_oe(p5_oe), .separate_bus(separate_bus));

    pm_pin_model #(.W(8)) i_p2 (.mclk(mclk), .pin_out(p2_out),
        .pin_oe(p2_oe), .pin_pullup(no_pull), .ext_drv(ext_pat),
        .ext_en(ext_en), .pin_in(p2_in));
    pm_pin_model #(.W(8)) i_p3 (.mclk(mclk), .pin_out(p3_out),
        .pin_oe(p3_oe), .pin_pullup(p3_pullup), .ext_drv(ext_pat),
        .ext_en(ext_en), .pin_in(p3_in));
    pm_pin_model #(.W(5)) i_p4 (.mclk(mclk), .pin_out(p4_out),
        .pin_oe(p4_oe), .pin_pullup(p4_pullup), .ext_drv(ext_pat[4:0]),
        .ext_en(ext_en), .pin_in(p4_in));
    pm_pin_model #(.W(8)) i_p5 (.mclk(mclk), .pin_out(p5_out),
        .pin_oe(p5_oe), .pin_pullup(no_pull), .ext_drv(ext_pat),
        .ext_en(ext_en), .pin_in(p5_in));

    task automatic final_report;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one setup and one access; waits on pready with a bound
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            final_report();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(a, 1'b0, 8'h00);
        chk(rdata, e);
    endtask

    // straps are held steady through reset and start-up
    task automatic do_reset(input logic b, input logic p);
        @(posedge mclk);
        rst_b <= 1'b0;
        bus_mode_strap <= b;
        reset_pullup_select <= p;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    initial
    begin
        {mclk, rst_b, psel, penable, pwrite, bus_mode_strap} = '0;
        {reset_pullup_select, bus_grant_ack, sysclk, ext_en} = '0;
        {clk_en, ext_rd_n, ext_wr_n, chip_select_n} = '1;
        {paddr, pwdata, ext_addr} = '0;
        {ext_pat, no_pull} = {8'h69, 8'h00};
        for (int i = 3; i >= 0; i--)
        begin
            {bm, pu} = 2'(i);
            do_reset(bm, pu);
            chk(32'(p2_oe), 32'h0);
            chk(32'(p3_oe), 32'({bm, 7'h03}));
            chk(32'(p3_out), 32'({~bm, {5{pu}}, 2'b11}));
            chk(32'(p3_pullup), 32'({{5{pu}}, 2'b00}));
            chk(32'(p4_pullup), 32'({1'b0, {4{pu}}}));
            chk(32'(p4_out), 32'({1'b1, {4{pu}}}));
            chk(32'({p4_oe, p5_oe, p5_out}), 32'hff);
            chk(32'(separate_bus), 32'(!bm));
            rd(12'h058, 32'h0);
            rd(12'hffc, 32'({1'b1, pu, bm}));
        end
        ext_en <= 1'b1;
        wr(12'h044, 8'h5a);
        wr(12'h058, 8'hcc);
        wr(12'h05c, 8'haa);
        for (int k = 0; k < 2; k++)
        begin
            ext_addr <= k ? 24'h5a00c3 : 24'ha5003c;
            @(posedge mclk);
            exp2 = 8'h5a;
            for (int b = 0; b < 8; b++)
                if (b[1])
                    exp2[b] = b[0] ? ext_addr[16+b] : ext_addr[b];
            chk(32'(p2_oe), 32'hee);
            chk(32'(p2_out & p2_oe), 32'(exp2 & 8'hee));
        end
        rd(12'h044, 32'h4b);
        chk(32'(rerr), 32'h0);
        rd(12'h100, 32'h0);
        chk(32'(rerr), 32'h1);
        wr(12'h060, 8'h47);
        for (int k = 0; k < 4; k++)
        begin
            {bus_grant_ack, ext_wr_n, ext_rd_n} <= {k[1], k[1], k[0]};
            @(posedge mclk);
            chk(32'(p3_oe[1:0]), 32'h3);
            chk(32'(p3_out[1:0]), 32'(k[1:0]));
            chk(32'(p3_pullup), k[1] ? 32'h44 : 32'h0);
        end
        wr(12'h088, 8'h1f);
        for (int k = 0; k < 2; k++)
        begin
            {sysclk, chip_select_n} <= k ? 5'h1a : 5'h05;
            @(posedge mclk);
            chk(32'(p4_oe), 32'h1f);
            chk(32'(p4_out), k ? 32'h1a : 32'h05);
        end
        wr(12'h088, 8'h05);
        wr(12'h074, 8'hff);
        @(posedge mclk);
        chk(32'({p4_oe, p4_out}), 32'({5'h05, 5'h1a}));
        rd(12'h074, 32'h0d);
        // a write while the enable is low must leave the latch alone
        clk_en <= 1'b0;
        wr(12'h074, 8'h00);
        clk_en <= 1'b1;
        @(posedge mclk);
        chk(32'({p4_oe, p4_out}), 32'({5'h05, 5'h1a}));
        for (int m = 0; m < 2; m++)
        begin
            do_reset(m[0], 1'b0);
            ext_addr <= 24'h0000c3;
            wr(12'h0ac, 8'h00);
            wr(12'h0b8, 8'h33);
            wr(12'h0bc, 8'h55);
            @(posedge mclk);
            chk(32'(p5_oe), 32'h55);
            chk(32'(p5_out & p5_oe), m ? 32'h0 : 32'h01);
        end
        final_report();
    end
endmodule

bind pm_port_mux pm_port_mux_monitor #(.ADDR_W(ADDR_W)) i_mon (
    .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
    .bus_mode_strap(bus_mode_strap),
    .reset_pullup_select(reset_pullup_select), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .paddr(paddr),
    .pwdata(pwdata), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n),
    .chip_select_n(chip_select_n), .sysclk(sysclk),
    .bus_grant_ack(bus_grant_ack), .p2_oe(p2_oe), .p3_out(p3_out),
    .p3_oe(p3_oe), .p3_pullup(p3_pullup), .p4_out(p4_out), .p4_oe(p4_oe),
    .p4_pullup(p4_pullup), .p5_out(p5_out), .p5_oe(p5_oe));
`default_nettype wire
